/* verilog/cipher_switch_defines.vh */
// Constants for the cipher mode switch handshake
`ifndef CIPHER_SWITCH_DEFINES_VH
`define CIPHER_SWITCH_DEFINES_VH

// Frame number width and retry limits
`define FRAME_W 4
`define PT_TRIES 3'h5
`define FT_WINDOW 4'hB
// Mode-control message codes
`define MSG_W 3
`define MSG_NONE 3'h0
`define MSG_START_REQ 3'h1
`define MSG_START_CONF 3'h2
`define MSG_START_GRANT 3'h3
`define MSG_STOP_REQ 3'h4
`define MSG_STOP_CONF 3'h5
`define MSG_STOP_GRANT 3'h6
// Connection mode values
`define MODE_CLEAR 1'b0
`define MODE_CIPHER 1'b1

`endif

/* verilog/frame_counter.v */
// Frame counter whose low bit gives frame parity
`timescale 1ns/100ps
`include "cipher_switch_defines.vh"
module frame_counter (
  // Clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // Frame timing
  input wire frame_start_i,
  input wire [`FRAME_W-1:0] frame_load_i,
  input wire frame_load_en_i,
  output reg [`FRAME_W-1:0] frame_num_o
);

  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      frame_num_o <= {`FRAME_W{1'b0}};
    end else if (frame_load_en_i) begin
      frame_num_o <= frame_load_i;
    end else if (frame_start_i) begin
      frame_num_o <= frame_num_o + {{(`FRAME_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

/* verilog/mode_tracker.v */
// Holds the connection cipher mode shared by all bearers
`timescale 1ns/100ps
`include "cipher_switch_defines.vh"
module mode_tracker (
  // Clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // Mode changes
  input wire set_cipher_i,
  input wire set_clear_i,
  input wire conn_new_i,
  output reg mode_o
);

  // New connections (handover legs) always start clear
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      mode_o <= `MODE_CLEAR;
    end else if (conn_new_i) begin
      mode_o <= `MODE_CLEAR;
    end else if (set_cipher_i) begin
      mode_o <= `MODE_CIPHER;
    end else if (set_clear_i) begin
      mode_o <= `MODE_CLEAR;
    end
  end

endmodule

/* verilog/cipher_mode_switch.v */
// Cipher mode switch handshake, portable or fixed role
`timescale 1ns/100ps
`include "cipher_switch_defines.vh"
module cipher_mode_switch (
  // Clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // Role: high for fixed side, low for portable side
  input wire is_fixed_i,
  // Frame timing
  input wire frame_start_i,
  input wire [`FRAME_W-1:0] frame_load_i,
  input wire frame_load_en_i,
  // Upper layer
  input wire switch_req_i,
  input wire switch_to_cipher_i,
  input wire conn_new_i,
  output reg switch_cfm_o,
  output reg switch_ind_o,
  output reg disconnect_o,
  // Received mode-control message, valid at frame end
  input wire rx_msg_valid_i,
  input wire [`MSG_W-1:0] rx_msg_i,
  // Transmit and receive side, valid for the current frame
  output reg [`MSG_W-1:0] tx_msg_o,
  output reg tx_cipher_o,
  output reg rx_cipher_o,
  output reg rx_discard_o,
  output reg bearer_mode_o,
  output reg [`FRAME_W-1:0] frame_num_o
);

  //****************************************
  // Frame counter and connection mode
  //****************************************
  wire [`FRAME_W-1:0] frame_num;
  wire conn_mode;
  reg set_cipher;
  reg set_clear;

  frame_counter u_frame (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .frame_start_i(frame_start_i),
    .frame_load_i(frame_load_i),
    .frame_load_en_i(frame_load_en_i),
    .frame_num_o(frame_num)
  );

  mode_tracker u_mode (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .set_cipher_i(set_cipher),
    .set_clear_i(set_clear),
    .conn_new_i(conn_new_i),
    .mode_o(conn_mode)
  );

  //****************************************
  // Handshake state machine
  //****************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_PT_REQ = 3'h1;
  localparam [2:0] ST_PT_GRANT = 3'h2;
  localparam [2:0] ST_FT_CONF = 3'h3;
  localparam [2:0] ST_RELEASED = 3'h4;

  reg [2:0] state_q, state_d;
  reg dir_q, dir_d;
  reg [2:0] tries_q, tries_d;
  reg [`FRAME_W-1:0] base_q, base_d;
  reg pend_q, pend_d;
  reg discard_q, discard_d;
  reg rxc_q, rxc_d;
  reg txc_q, txc_d;
  reg [`MSG_W-1:0] msg_d;
  reg cfm_d, ind_d, dis_d;

  wire even = ~frame_num[0];
  wire [`FRAME_W-1:0] since = frame_num - base_q;

  // True when a message is a request of either direction
  function is_req;
    input [`MSG_W-1:0] m;
    begin
      is_req = (m == `MSG_START_REQ) || (m == `MSG_STOP_REQ);
    end
  endfunction

  // Pick the message that matches the switch direction
  function [`MSG_W-1:0] pick;
    input d;
    input [`MSG_W-1:0] a;
    input [`MSG_W-1:0] b;
    begin
      pick = d ? a : b;
    end
  endfunction

  always @* begin
    state_d = state_q;
    dir_d = dir_q;
    tries_d = tries_q;
    base_d = base_q;
    pend_d = pend_q | switch_req_i;
    discard_d = discard_q;
    rxc_d = rxc_q;
    txc_d = txc_q;
    msg_d = `MSG_NONE;
    cfm_d = 1'b0;
    ind_d = 1'b0;
    dis_d = 1'b0;
    set_cipher = 1'b0;
    set_clear = 1'b0;
    if (switch_req_i) begin
      dir_d = switch_to_cipher_i;
    end
    case (state_q)
      ST_IDLE: begin
        // Portable starts at the next even frame boundary
        if (!is_fixed_i && pend_q && frame_start_i && frame_num[0]) begin
          state_d = ST_PT_REQ;
          tries_d = 3'h0;
          pend_d = 1'b0;
          discard_d = 1'b1;
        end
        if (is_fixed_i && rx_msg_valid_i && even && is_req(rx_msg_i)) begin
          dir_d = (rx_msg_i == `MSG_START_REQ);
          state_d = ST_FT_CONF;
          base_d = frame_num;
          // Fixed switches transmit mode at once
          txc_d = (rx_msg_i == `MSG_START_REQ);
          set_cipher = (rx_msg_i == `MSG_START_REQ);
          set_clear = (rx_msg_i == `MSG_STOP_REQ);
        end
      end
      ST_PT_REQ: begin
        if (even) begin
          msg_d = pick(dir_q, `MSG_START_REQ, `MSG_STOP_REQ);
        end
        if (rx_msg_valid_i && !even &&
            rx_msg_i == pick(dir_q, `MSG_START_CONF, `MSG_STOP_CONF)) begin
          state_d = ST_PT_GRANT;
          cfm_d = 1'b1;
          discard_d = 1'b0;
          rxc_d = dir_q;
        end else if (frame_start_i && even) begin
          tries_d = tries_q + 3'h1;
          if (tries_q + 3'h1 == `PT_TRIES) begin
            state_d = ST_RELEASED;
            dis_d = 1'b1;
          end
        end
      end
      ST_PT_GRANT: begin
        // Grant frame is the first with the new transmit mode; the
        // state is held through that whole even frame so the grant
        // really goes out before returning to idle
        if (even) begin
          msg_d = pick(dir_q, `MSG_START_GRANT, `MSG_STOP_GRANT);
          txc_d = dir_q;
        end
        if (frame_start_i && even) begin
          state_d = ST_IDLE;
          if (dir_q) begin
            set_cipher = 1'b1;
          end else begin
            set_clear = 1'b1;
          end
        end
      end
      ST_FT_CONF: begin
        if (!even && since <= `FT_WINDOW) begin
          msg_d = pick(dir_q, `MSG_START_CONF, `MSG_STOP_CONF);
        end
        // Data after 2S+1 is dropped until the grant; any early
        // decryption result is simply masked here
        discard_d = (since > {{(`FRAME_W-1){1'b0}}, 1'b1});
        if (rx_msg_valid_i && even &&
            rx_msg_i == pick(dir_q, `MSG_START_GRANT, `MSG_STOP_GRANT)) begin
          state_d = ST_IDLE;
          ind_d = 1'b1;
          discard_d = 1'b0;
          rxc_d = dir_q;
        end else if (frame_start_i && since >= `FT_WINDOW) begin
          state_d = ST_RELEASED;
          dis_d = 1'b1;
          discard_d = 1'b0;
        end
      end
      ST_RELEASED: begin
        // Held until a new connection is signalled
        if (conn_new_i) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (conn_new_i) begin
      rxc_d = `MODE_CLEAR;
      txc_d = `MODE_CLEAR;
      discard_d = 1'b0;
      pend_d = 1'b0;
      state_d = ST_IDLE;
    end
  end

  //****************************************
  // Registers and outputs
  //****************************************
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      dir_q <= 1'b0;
      tries_q <= 3'h0;
      base_q <= {`FRAME_W{1'b0}};
      pend_q <= 1'b0;
      discard_q <= 1'b0;
      rxc_q <= `MODE_CLEAR;
      txc_q <= `MODE_CLEAR;
      tx_msg_o <= `MSG_NONE;
      switch_cfm_o <= 1'b0;
      switch_ind_o <= 1'b0;
      disconnect_o <= 1'b0;
      tx_cipher_o <= 1'b0;
      rx_cipher_o <= 1'b0;
      rx_discard_o <= 1'b0;
      bearer_mode_o <= `MODE_CLEAR;
      frame_num_o <= {`FRAME_W{1'b0}};
    end else begin
      state_q <= state_d;
      dir_q <= dir_d;
      tries_q <= tries_d;
      base_q <= base_d;
      pend_q <= pend_d;
      discard_q <= discard_d;
      rxc_q <= rxc_d;
      txc_q <= txc_d;
      // Mode-control messages go out in the frame's transmit mode; start confirm and start grant with tx_cipher_o high
      tx_msg_o <= msg_d;
      switch_cfm_o <= cfm_d;
      switch_ind_o <= ind_d;
      disconnect_o <= dis_d;
      tx_cipher_o <= txc_d;
      rx_cipher_o <= rxc_d;
      rx_discard_o <= discard_d;
      // Every bearer, including ones set up later, follows this
      // mode with the same key and init value per frame number
      bearer_mode_o <= conn_mode;
      frame_num_o <= frame_num;
    end
  end

endmodule

/* verification/cipher_switch_checker_assertions.sv */
// Port assertions for the cipher mode switch
`timescale 1ns/100ps
`include "cipher_switch_defines.vh"
module cipher_switch_checker (
  // Clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // Watched ports
  input wire is_fixed_i,
  input wire switch_to_cipher_i,
  input wire rx_msg_valid_i,
  input wire [`MSG_W-1:0] rx_msg_i,
  input wire switch_cfm_o,
  input wire disconnect_o,
  input wire [`MSG_W-1:0] tx_msg_o,
  input wire tx_cipher_o,
  input wire rx_cipher_o,
  input wire rx_discard_o,
  input wire [`FRAME_W-1:0] frame_num_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  wire fx = is_fixed_i;
  wire [`MSG_W-1:0] m = tx_msg_o;
  msg_parity_a: assert property (
    m != `MSG_NONE |-> frame_num_o[0] == fx) else $error("bad parity");
  start_discard_a: assert property (
    !fx && m == `MSG_START_REQ |-> rx_discard_o) else $error("no discard");
  grant_cipher_a: assert property (
    !fx && m == `MSG_START_GRANT |-> tx_cipher_o) else $error("grant clear");
  grant_clear_a: assert property (
    !fx && m == `MSG_STOP_GRANT |-> !tx_cipher_o) else $error("grant coded");
  cfm_decrypt_a: assert property (
    switch_cfm_o |-> rx_cipher_o == switch_to_cipher_i) else $error("rx mode");
  conf_mode_a: assert property (
    fx && m != `MSG_NONE |-> tx_cipher_o == (m == `MSG_START_CONF))
    else $error("conf mode");
  req_enter_a: assert property (
    fx && rx_msg_valid_i && rx_msg_i == `MSG_START_REQ && !frame_num_o[0]
    |=> tx_cipher_o) else $error("no encrypt");
  grant_soon_a: assert property (
    $rose(switch_cfm_o) |->
    ##[1:10] (m == `MSG_START_GRANT || m == `MSG_STOP_GRANT))
    else $error("no grant");
  release_quiet_a: assert property (
    disconnect_o |=> (m == `MSG_NONE) [*4]) else $error("talk after release");
endmodule

bind cipher_mode_switch cipher_switch_checker u_chk (.core_clk_i, .nrst_i,
  .is_fixed_i, .switch_to_cipher_i, .rx_msg_valid_i, .rx_msg_i,
  .switch_cfm_o, .disconnect_o, .tx_msg_o, .tx_cipher_o, .rx_cipher_o,
  .rx_discard_o, .frame_num_o);

/* verification/peer_mac.sv */
// Far-side peer: frame timing and handshake replies
`timescale 1ns/100ps
`include "cipher_switch_defines.vh"
module peer_mac (
  // Clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // Scenario control
  input wire peer_fixed_i,
  input wire go_i,
  input wire [`MSG_W-1:0] go_req_i,
  input wire [3:0] skip_i,
  // Near side heard over the air
  input wire [`MSG_W-1:0] near_msg_i,
  input wire parity_i,
  // Towards the near side
  output reg frame_start_o = 1'b0,
  output reg rx_valid_o = 1'b0,
  output reg [`MSG_W-1:0] rx_msg_o = 3'h0
);
  reg [2:0] cnt_q = 3'h0;
  reg [`MSG_W-1:0] ans_q;
  reg [3:0] skip_q;
  reg gr_q;
  // Own messages only in own parity frames, just before frame end
  wire send = cnt_q == 3'h6 && ans_q != 3'h0 && parity_i == peer_fixed_i;
  wire seen = cnt_q == 3'h3 && parity_i != peer_fixed_i;
  always @(posedge core_clk_i) begin
    cnt_q <= cnt_q + 3'h1;
    if (!nrst_i || go_i) begin
      ans_q <= go_req_i;
      skip_q <= skip_i;
      gr_q <= 1'b0;
    end else if (send && gr_q) begin
      ans_q <= `MSG_NONE;
      gr_q <= 1'b0;
    end else if (seen && (near_msg_i == `MSG_START_GRANT ||
                          near_msg_i == `MSG_STOP_GRANT)) begin
      ans_q <= `MSG_NONE;
    end else if (seen && near_msg_i != `MSG_NONE) begin
      // Skipped replies model a poor link, as the scenario commands
      if (skip_q != 4'h0) begin
        skip_q <= skip_q - 4'h1;
      end else begin
        ans_q <= near_msg_i + 3'h1;
        gr_q <= !peer_fixed_i;
      end
    end
  end
  // Idle data lines toggle so a stale code never looks valid
  always @(negedge core_clk_i) begin
    frame_start_o <= cnt_q == 3'h7;
    rx_valid_o <= send;
    rx_msg_o <= send ? ans_q : ~rx_msg_o;
  end
endmodule

/* verification/cipher_mode_switch_handshake_tb_top.sv */
// Self-checking bench for the cipher mode switch handshake
`timescale 1ns/100ps
`include "cipher_switch_defines.vh"
module cipher_mode_switch_handshake_tb_top;
  reg core_clk_i = 1'b0;
  reg nrst_i = 1'b0;
  reg is_fixed_i = 1'b0;
  reg switch_req_i = 1'b0;
  reg switch_to_cipher_i = 1'b0;
  reg conn_new_i = 1'b0;
  reg [`FRAME_W-1:0] frame_load_i = 4'h0;
  reg frame_load_en_i = 1'b0;
  reg go_i = 1'b0;
  reg [`MSG_W-1:0] go_req_i = 3'h0;
  reg [3:0] skip_i = 4'h0;
  reg [`MSG_W-1:0] watch = 3'h0;
  reg [31:0] rnd;
  wire frame_start_i, rx_msg_valid_i, switch_cfm_o, switch_ind_o;
  wire disconnect_o, tx_cipher_o, rx_cipher_o, rx_discard_o, bearer_mode_o;
  wire [`MSG_W-1:0] rx_msg_i, tx_msg_o;
  wire [`FRAME_W-1:0] frame_num_o;
  integer num_errors = 0;
  integer cmp_count = 0;
  integer nmsg = 0;
  integer tnum = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  cipher_mode_switch u_cipher_mode_switch (.core_clk_i, .nrst_i, .is_fixed_i,
    .frame_start_i, .frame_load_i, .frame_load_en_i, .switch_req_i,
    .switch_to_cipher_i, .conn_new_i, .switch_cfm_o, .switch_ind_o,
    .disconnect_o, .rx_msg_valid_i, .rx_msg_i, .tx_msg_o, .tx_cipher_o,
    .rx_cipher_o, .rx_discard_o, .bearer_mode_o, .frame_num_o);
  peer_mac u_peer_mac (.core_clk_i, .nrst_i, .peer_fixed_i(!is_fixed_i),
    .go_i, .go_req_i, .skip_i, .near_msg_i(tx_msg_o),
    .parity_i(frame_num_o[0]), .frame_start_o(frame_start_i),
    .rx_valid_o(rx_msg_valid_i), .rx_msg_o(rx_msg_i));
  // Frames that carried the watched code, counted as each frame ends
  always @(posedge core_clk_i)
    if (frame_start_i && tx_msg_o === watch)
      nmsg = nmsg + 1;
  function [3:0] exp_tries(input [3:0] skip, input [3:0] lim);
    exp_tries = skip >= lim ? lim : skip + 4'h1;
  endfunction
  task chk(input [3:0] got, input [3:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task wait_ev(input [1:0] w);
    integer i;
    reg hit;
    begin
      hit = 1'b0;
      for (i = 0; i < 400 && !hit; i = i + 1) begin
        @(posedge core_clk_i);
        #1;
        hit = (w == 0 ? switch_cfm_o : w == 1 ? switch_ind_o :
               disconnect_o) === 1'b1;
      end
      if (!hit) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t wait timed out", $time);
        complete_run;
      end
    end
  endtask
  task settle(input integer n);
    begin
      repeat (n) @(posedge core_clk_i);
      #1;
    end
  endtask
  task reset_role(input fx);
    begin
      @(negedge core_clk_i);
      nrst_i = 1'b0;
      is_fixed_i = fx;
      repeat (20) @(negedge core_clk_i);
      nrst_i = 1'b1;
    end
  endtask
  task start_op(input dir, input [`MSG_W-1:0] req, input [3:0] skip);
    begin
      @(negedge core_clk_i);
      rnd = $urandom;
      frame_load_i = rnd[3:0];
      frame_load_en_i = 1'b1;
      go_i = 1'b1;
      go_req_i = req;
      skip_i = skip;
      switch_to_cipher_i = dir;
      switch_req_i = !is_fixed_i;
      nmsg = 0;
      @(negedge core_clk_i);
      frame_load_en_i = 1'b0;
      go_i = 1'b0;
      switch_req_i = 1'b0;
    end
  endtask
  task end_op(input dis);
    begin
      if (dis) begin
        @(negedge core_clk_i);
        conn_new_i = 1'b1;
        @(negedge core_clk_i);
        conn_new_i = 1'b0;
        settle(1);
        chk(bearer_mode_o, 1'b0);
        chk(tx_msg_o, `MSG_NONE);
      end
      tnum = tnum + 1;
      $display("test %0d done", tnum);
    end
  endtask
  task port_op(input dir, input [3:0] skip);
    begin
      watch = dir ? `MSG_START_REQ : `MSG_STOP_REQ;
      start_op(dir, `MSG_NONE, skip);
      wait_ev(skip > 4 ? 2'h2 : 2'h0);
      if (skip < 5) chk(rx_cipher_o, dir);
      settle(3);
      if (skip < 5) begin
        chk(tx_msg_o, dir ? `MSG_START_GRANT : `MSG_STOP_GRANT);
        chk(tx_cipher_o, dir);
      end
      settle(13);
      chk(nmsg, exp_tries(skip, {1'b0, `PT_TRIES}));
      if (skip < 5) chk(bearer_mode_o, dir);
      end_op(skip > 4);
    end
  endtask
  task fix_op(input dir, input [3:0] skip);
    begin
      watch = dir ? `MSG_START_CONF : `MSG_STOP_CONF;
      start_op(dir, dir ? `MSG_START_REQ : `MSG_STOP_REQ, skip);
      wait_ev(skip > 5 ? 2'h2 : 2'h1);
      if (skip < 6) chk(rx_cipher_o, dir);
      @(negedge core_clk_i);
      go_i = 1'b1;
      go_req_i = `MSG_NONE;
      @(negedge core_clk_i);
      go_i = 1'b0;
      settle(16);
      chk(nmsg, exp_tries(skip, (`FT_WINDOW + 4'h1) >> 1));
      end_op(skip > 5);
    end
  endtask
  initial begin
    rnd = $urandom(32'h689A);
    reset_role(1'b0);
    rnd = $urandom;
    port_op(1'b1, {2'h0, rnd[1:0]});
    port_op(1'b0, {2'h0, rnd[3:2]});
    port_op(1'b1, 4'hF);
    reset_role(1'b1);
    rnd = $urandom;
    fix_op(1'b1, {2'h0, rnd[1:0]} + {3'h0, rnd[2]});
    fix_op(1'b0, {2'h0, rnd[4:3]});
    fix_op(1'b1, 4'h6);
    complete_run;
  end
endmodule
